// [dv/mpst_display_model.sv]
`timescale 1ns/10ps
module mpst_display_model (
  // Sync pair from the device
  input  wire logic       i_hsync_act,
  input  wire logic       i_vsync_act,
  // Decoded power mode
  output logic      [1:0] o_mode
);
  // Vertical-only activity is no defined mode, so it decodes as 3
  always_comb begin
    case ({i_hsync_act, i_vsync_act})
      2'h3:    o_mode = 2'h0;
      2'h2:    o_mode = 2'h1;
      2'h0:    o_mode = 2'h2;
      default: o_mode = 2'h3;
    endcase
  end
endmodule : mpst_display_model

// [dv/mpst_monitor_power_tb_top.sv]
`timescale 1ns/10ps
module mpst_monitor_power_tb_top;
  localparam int M    = 8;
  localparam int OFFP = 2;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic       act = 1'b0;
  logic       en  = 1'b0;
  logic       ack = 1'b0;
  logic [7:0] sus = 8'h00;
  logic [7:0] aut = 8'h00;
  logic       hs;
  logic       vs;
  logic       smi;
  logic [1:0] st;
  logic [1:0] mode;
  int         err_total = 0;
  int         n_tests   = 0;
  int         exp_st    = 0;
  int         n;
  int         f;

  always #5 clk = ~clk;

  mpst_monitor_power #(.MINUTE_CNT(M), .OFF_SMI_PRESET(6'(OFFP))) dut_u (
    .I_CLK_SYS(clk), .I_RESET(rst), .I_IO_ACTIVITY(act), .I_CMOS_SUSPEND(sus),
    .I_CMOS_OFF_AUTO(aut), .I_INACT_EN(en), .I_SMI_ACK(ack), .O_HSYNC_ACT(hs),
    .O_VSYNC_ACT(vs), .O_SMI(smi), .O_POWER_STATE(st));

  mpst_display_model mon_u (.i_hsync_act(hs), .i_vsync_act(vs), .o_mode(mode));

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("FAIL %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask : chk

  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : tally_and_finish

  task automatic chk_model();
    chk(8'(st), 8'(exp_st));
    chk({6'h00, hs, vs}, exp_st == 0 ? 8'h03 : exp_st == 1 ? 8'h02 : 8'h00);
    chk(8'(mode), 8'(exp_st));
  endtask : chk_model

  // One-cycle pulse: which=1 ack, else activity
  task automatic poke(input bit which);
    @(posedge clk);
    if (which) ack <= 1'b1;
    else act <= 1'b1;
    @(posedge clk);
    ack <= 1'b0;
    act <= 1'b0;
  endtask : poke

  // from=3 waits for the interrupt, else for the state to leave from
  task automatic wait_for(input logic [1:0] from, input int lim, output int cnt);
    cnt = 0;
    #1;
    while ((from == 2'h3 ? smi !== 1'b1 : st === from) && cnt < lim) begin
      @(posedge clk);
      #1;
      cnt++;
    end
    if (from == 2'h3 ? smi !== 1'b1 : st === from) begin
      chk(8'h00, 8'h01);
      tally_and_finish();
    end
  endtask : wait_for

  initial begin
    void'($urandom(46));
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    chk(8'(smi), 8'h00);
    chk_model();
    $display("test reset done");
    f = 1 + $urandom % 3;
    @(posedge clk);
    sus <= {3'($urandom), 5'(f)};
    aut <= 8'($urandom) & 8'hFD;
    en  <= 1'b1;
    poke(0);
    repeat (f * M / 2) @(posedge clk);
    #1;
    chk(8'(smi), 8'h00);
    poke(0);
    wait_for(2'h3, f * M + 20, n);
    chk(8'(n >= f * M && n <= f * M + 6), 8'h01);
    poke(1);
    wait_for(2'h0, 6, n);
    exp_st = 1;
    chk_model();
    chk(8'(smi), 8'h00);
    $display("test suspend done");
    wait_for(2'h3, OFFP * M + 20, n);
    chk(8'(n >= OFFP * M && n <= OFFP * M + 6), 8'h01);
    chk(8'(st), 8'h01);
    poke(1);
    wait_for(2'h1, 6, n);
    exp_st = 2;
    chk_model();
    poke(0);
    wait_for(2'h2, 8, n);
    exp_st = 0;
    chk_model();
    $display("test off and wake done");
    // Counter switched off, then a zero field with stray high bits
    for (int k = 0; k < 2; k++) begin
      @(posedge clk);
      sus <= k ? 8'hE0 : sus;
      poke(0);
      // Enable only after the reload, so a stale count cannot expire
      repeat (3) @(posedge clk);
      en  <= 1'(k);
      repeat (4 * M + 8) @(posedge clk);
      #1;
      chk(8'(smi), 8'h00);
      chk_model();
    end
    $display("test disabled done");
    @(posedge clk);
    sus <= 8'h01;
    aut <= 8'($urandom) | 8'h02;
    poke(0);
    wait_for(2'h3, M + 20, n);
    poke(1);
    wait_for(2'h0, 6, n);
    exp_st = 1;
    chk_model();
    // The two-minute interrupt is left pending; the auto timer must still act
    wait_for(2'h1, 45 * M + 40, n);
    chk(8'(n >= 45 * M - 4 && n <= 45 * M + 6), 8'h01);
    exp_st = 2;
    chk_model();
    chk(8'(smi), 8'h00);
    $display("test auto off done");
    // Reset again in Off: the monitor must come back On with no SMI
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    exp_st = 0;
    chk(8'(smi), 8'h00);
    chk_model();
    $display("test reset in off done");
    tally_and_finish();
  end
endmodule : mpst_monitor_power_tb_top

// [hw/mpst_monitor_power.sv]
// Behaviour
// RULE_01: Sync pair encodes On, Suspend, Off.
// RULE_02: On: inactivity countdown raises SMI to suspend.
// RULE_03: Suspend delay from five-bit field, 2Ch.
// RULE_04: Suspend: Off timer expiry raises SMI, goes Off.
// RULE_05: Enabled by 1Fh bit 1: Off after 45 minutes.
// RULE_06: Any I/O activity reloads the active timer.
`timescale 1ns/10ps
module mpst_monitor_power
  import mpst_pkg::*;
#(
  parameter longint    MINUTE_CNT      = MINUTE_CYCLES,
  parameter logic [5:0] OFF_SMI_PRESET = 6'h0F
) (
  // Clock and reset
  input  wire logic       I_CLK_SYS,
  input  wire logic       I_RESET,
  // System activity pin
  input  wire logic       I_IO_ACTIVITY,
  // Configuration memory bytes and handler control
  input  wire logic [7:0] I_CMOS_SUSPEND,
  input  wire logic [7:0] I_CMOS_OFF_AUTO,
  input  wire logic       I_INACT_EN,
  input  wire logic       I_SMI_ACK,
  // Monitor and handler outputs
  output logic            O_HSYNC_ACT,
  output logic            O_VSYNC_ACT,
  output logic            O_SMI,
  output logic [1:0]      O_POWER_STATE
);

  mpst_state_type   state_reg;
  mpst_state_type   state_next;
  mpst_sync_type    sync_reg;
  logic             act_meta_reg;
  logic             act_sync_reg;
  longint           pre_reg;
  logic             tick_reg;
  logic             smi_reg;
  logic             restart;
  logic [TMR_W-1:0] suspend_preset;
  logic             off_auto_en;
  logic [TMR_W-1:0] inact_count;
  logic             inact_expired;
  logic [TMR_W-1:0] offsmi_count;
  logic             offsmi_expired;
  logic             offauto_expired;

  assign suspend_preset = {1'b0, I_CMOS_SUSPEND[SUSPEND_FIELD_LSB +: SUSPEND_FIELD_W]}; // [RULE_03]
  assign off_auto_en    = I_CMOS_OFF_AUTO[OFF_AUTO_EN_BIT]; // [RULE_05]

  // Activity comes from a pin, so it is synchronised first
  always_ff @(posedge I_CLK_SYS) begin
    if (I_RESET) begin
      act_meta_reg <= 1'b0;
      act_sync_reg <= 1'b0;
    end else begin
      act_meta_reg <= I_IO_ACTIVITY;
      act_sync_reg <= act_meta_reg;
    end
  end

  // Restarting the minute base with the timers keeps every period whole
  assign restart = act_sync_reg || (state_next != state_reg); // [RULE_06]

  always_ff @(posedge I_CLK_SYS) begin
    if (I_RESET || restart) begin
      pre_reg  <= 64'd0;
      tick_reg <= 1'b0;
    end else if (pre_reg >= MINUTE_CNT - 64'd1) begin
      pre_reg  <= 64'd0;
      tick_reg <= 1'b1;
    end else begin
      pre_reg  <= pre_reg + 64'd1;
      tick_reg <= 1'b0;
    end
  end

  mpst_timer u_inact (
    .i_clk     (I_CLK_SYS),
    .i_reset   (I_RESET),
    .i_load    (restart || state_reg != ST_ON), // [RULE_06]
    .i_preset  (suspend_preset), // [RULE_03]
    .i_run     (state_reg == ST_ON && I_INACT_EN), // [RULE_02]
    .i_tick    (tick_reg),
    .o_count   (inact_count),
    .o_expired (inact_expired)
  );

  mpst_timer u_offsmi (
    .i_clk     (I_CLK_SYS),
    .i_reset   (I_RESET),
    .i_load    (restart || state_reg != ST_SUSPEND),
    .i_preset  (OFF_SMI_PRESET),
    .i_run     (state_reg == ST_SUSPEND), // [RULE_04]
    .i_tick    (tick_reg),
    .o_count   (offsmi_count),
    .o_expired (offsmi_expired)
  );

  mpst_timer u_offauto (
    .i_clk     (I_CLK_SYS),
    .i_reset   (I_RESET),
    .i_load    (restart || state_reg != ST_SUSPEND),
    .i_preset  (TMR_W'(OFF_AUTO_MIN)),
    .i_run     (state_reg == ST_SUSPEND && off_auto_en), // [RULE_05]
    .i_tick    (tick_reg),
    .o_count   (),
    .o_expired (offauto_expired)
  );

  // Activity wakes the monitor; the handler acknowledge steps it down
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_ON: begin
        if (smi_reg && I_SMI_ACK && !act_sync_reg) begin
          state_next = ST_SUSPEND; // [RULE_02]
        end
      end
      ST_SUSPEND: begin
        if (act_sync_reg) begin
          state_next = ST_ON;
        end else if (offauto_expired && off_auto_en) begin
          state_next = ST_OFF; // [RULE_05]
        end else if (smi_reg && I_SMI_ACK) begin
          state_next = ST_OFF; // [RULE_04]
        end
      end
      ST_OFF: begin
        if (act_sync_reg) begin
          state_next = ST_ON;
        end
      end
      default: begin
        state_next = ST_ON;
      end
    endcase
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (I_RESET) begin
      state_reg <= ST_ON;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (I_RESET) begin
      sync_reg <= SYNC_ON;
    end else begin
      case (state_next)
        ST_ON:      sync_reg <= SYNC_ON; // [RULE_01]
        ST_SUSPEND: sync_reg <= SYNC_SUSPEND; // [RULE_01]
        default:    sync_reg <= SYNC_OFF; // [RULE_01]
      endcase
    end
  end

  // A new expiry wins over an acknowledge in the same cycle
  always_ff @(posedge I_CLK_SYS) begin
    if (I_RESET) begin
      smi_reg <= 1'b0;
    end else if ((inact_expired && state_reg == ST_ON) ||
                 (offsmi_expired && state_reg == ST_SUSPEND)) begin
      smi_reg <= 1'b1; // [RULE_02] [RULE_04]
    end else if (I_SMI_ACK || act_sync_reg || state_next != state_reg) begin
      smi_reg <= 1'b0;
    end
  end

  assign O_HSYNC_ACT   = sync_reg.hsync_act;
  assign O_VSYNC_ACT   = sync_reg.vsync_act;
  assign O_SMI         = smi_reg;
  assign O_POWER_STATE = state_reg;

  sequence s_suspend_ack;
    state_reg == ST_SUSPEND && smi_reg && I_SMI_ACK && !act_sync_reg && !offauto_expired;
  endsequence

  property p_sync_code;
    @(posedge I_CLK_SYS) disable iff (I_RESET)
      (state_reg == ST_ON) == (O_HSYNC_ACT && O_VSYNC_ACT) &&
      (state_reg == ST_OFF) == (!O_HSYNC_ACT && !O_VSYNC_ACT) && O_VSYNC_ACT <= O_HSYNC_ACT;
  endproperty
  a_sync_code: assert property (p_sync_code) else $error("sync pair mismatches state"); // [RULE_01]

  property p_inact_smi;
    @(posedge I_CLK_SYS) disable iff (I_RESET)
      inact_expired && state_reg == ST_ON |=> O_SMI;
  endproperty
  a_inact_smi: assert property (p_inact_smi) else $error("no SMI on inactivity expiry"); // [RULE_02]

  // A field change alone must not matter; only a reload takes the new value
  property p_field_bound;
    @(posedge I_CLK_SYS) disable iff (I_RESET)
      $past(restart) && state_reg == ST_ON |-> inact_count == $past(suspend_preset);
  endproperty
  a_field_bound: assert property (p_field_bound) else $error("inactivity count above field"); // [RULE_03]

  property p_offsmi;
    @(posedge I_CLK_SYS) disable iff (I_RESET)
      offsmi_expired && state_reg == ST_SUSPEND |=> O_SMI;
  endproperty
  a_offsmi: assert property (p_offsmi) else $error("no SMI on off timer expiry"); // [RULE_04]

  property p_ack_off;
    @(posedge I_CLK_SYS) disable iff (I_RESET)
      s_suspend_ack |=> state_reg == ST_OFF && !O_HSYNC_ACT && !O_VSYNC_ACT;
  endproperty
  a_ack_off: assert property (p_ack_off) else $error("serviced SMI did not reach Off"); // [RULE_04]

  property p_auto_off;
    @(posedge I_CLK_SYS) disable iff (I_RESET)
      offauto_expired && off_auto_en && state_reg == ST_SUSPEND && !act_sync_reg
      |=> state_reg == ST_OFF && !O_HSYNC_ACT && !O_VSYNC_ACT;
  endproperty
  a_auto_off: assert property (p_auto_off) else $error("auto off missed"); // [RULE_05]

  property p_reload;
    @(posedge I_CLK_SYS) disable iff (I_RESET)
      act_sync_reg && state_reg == ST_ON && !inact_expired
      |=> inact_count == $past(suspend_preset) && !O_SMI;
  endproperty
  a_reload: assert property (p_reload) else $error("activity did not reload timer"); // [RULE_06]

  property p_no_early;
    @(posedge I_CLK_SYS) disable iff (I_RESET)
      act_sync_reg |=> !inact_expired [*2];
  endproperty
  a_no_early: assert property (p_no_early) else $error("expiry right after activity"); // [RULE_06]

endmodule : mpst_monitor_power

// [hw/mpst_pkg.sv]
package mpst_pkg;

  // Clock and time base
  localparam int unsigned  CLK_PERIOD_NS = 10;
  localparam longint       MINUTE_NS     = 64'd60000000000;
  localparam longint       MINUTE_CYCLES = MINUTE_NS / CLK_PERIOD_NS;
  localparam int unsigned  OFF_AUTO_MIN  = 45;

  // Configuration memory locations and field positions
  localparam logic [7:0]   CMOS_SUSPEND_LOC  = 8'h2C;
  localparam int unsigned  SUSPEND_FIELD_LSB = 0;
  localparam int unsigned  SUSPEND_FIELD_W   = 5;
  localparam logic [7:0]   CMOS_OFF_AUTO_LOC = 8'h1F;
  localparam int unsigned  OFF_AUTO_EN_BIT   = 1;

  // Timer width in minutes, enough for the 45 minute limit
  localparam int unsigned  TMR_W             = 6;
  localparam logic [5:0]   TMR_RESET_VALUE   = 6'h00;

  typedef enum logic [1:0] {
    ST_ON,
    ST_SUSPEND,
    ST_OFF
  } mpst_state_type;

  typedef struct packed {
    logic hsync_act;
    logic vsync_act;
  } mpst_sync_type;

  localparam mpst_sync_type SYNC_ON      = '{hsync_act: 1'b1, vsync_act: 1'b1};
  localparam mpst_sync_type SYNC_SUSPEND = '{hsync_act: 1'b1, vsync_act: 1'b0};
  localparam mpst_sync_type SYNC_OFF     = '{hsync_act: 1'b0, vsync_act: 1'b0};

endpackage : mpst_pkg

// [hw/mpst_timer.sv]
`timescale 1ns/10ps
module mpst_timer
  import mpst_pkg::*;
(
  // Clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_reset,
  // Control
  input  wire logic             i_load,
  input  wire logic [TMR_W-1:0] i_preset,
  input  wire logic             i_run,
  input  wire logic             i_tick,
  // Status
  output logic      [TMR_W-1:0] o_count,
  output logic                  o_expired
);

  logic [TMR_W-1:0] count_reg;
  logic             expired_reg;

  // A preset of zero never expires, so a zero field disables the timer
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      count_reg <= TMR_RESET_VALUE;
    end else if (i_load) begin
      count_reg <= i_preset;
    end else if (i_run && i_tick && count_reg != '0) begin
      count_reg <= count_reg - 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      expired_reg <= 1'b0;
    end else begin
      expired_reg <= !i_load && i_run && i_tick && count_reg == {{(TMR_W-1){1'b0}}, 1'b1};
    end
  end

  assign o_count   = count_reg;
  assign o_expired = expired_reg;

endmodule : mpst_timer
